// [verilog/hwf_hold_wake_flags.sv]
// Hold, wake-source and interrupt flag logic of a small 4-bit controller.
// Assumes the core issues one flag command per cycle on clk_in, pulses
// irq_ack_in when it jumps to irq_vector_out, and stops while core_halt_out.
//
// What this block does
// - Hold halts core; clocks and timers continue
// - Nine sources can end hold
// - Any cause bit set ends hold
// - Cause bits hardware-set, cleared with event/enable
// - Hold enable bit order plus port D
// - Interrupt enable uses same source order
// - Taken interrupt clears only its event
// - Taking masks all until re-enabled
// - Port mask gates C both, D hold
// - Edge mask bits gate external hold release
// - Cause read as nibbles; port D hidden
// - Cause bits follow enable order
// - Events hardware-set, cleared by software/accept
// - Per-pin change status for C and D
// - Reset clears every flag and mask
// - Interrupt needs event and enables
// - Interrupt in hold runs, then resumes hold
// - One vector per source in table
`timescale 1ns/1ps
`default_nettype none
module hwf_hold_wake_flags
   import hwf_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 reset_n_in,
   input  wire hwf_cmd_s             cmd_in,
   input  wire hwf_tick_s            tick_in,
   input  wire logic                 irq_ack_in,
   input  wire logic [NIB_W-1:0]     port_c_pin_in,
   input  wire logic [NIB_W-1:0]     port_d_pin_in,
   input  wire logic                 first_ext_edge_input_in,
   input  wire logic                 second_ext_edge_input_in,
   output var  logic                 hold_out,
   output var  logic                 core_halt_out,
   output var  logic                 irq_req_out,
   output var  logic [VEC_W-1:0]     irq_vector_out,
   output var  logic [FLAG_W-1:0]    rd_data_out,
   output var  logic                 rd_valid_out,
   output var  logic [FLAG_W-1:0]    stop_wake_mask_out
);

   // ***************************************************
   // Reset release
   // ***************************************************
   logic [1:0] rst_pipe;
   logic       rst_n;

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end

   assign rst_n = rst_pipe[1];

   // ***************************************************
   // Pin capture
   // ***************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_sync;
   logic [PIN_W-1:0] pin_change;
   logic [PIN_W-1:0] pin_fall;

   assign pin_raw = {second_ext_edge_input_in, first_ext_edge_input_in, port_d_pin_in, port_c_pin_in};

   hwf_sync2 #(.WIDTH(PIN_W)) u_sync
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n),
      .async_in (pin_raw),
      .sync_out (pin_sync)
   );

   hwf_pin_watch #(.WIDTH(PIN_W)) u_watch
   (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n),
      .pin_in     (pin_sync),
      .change_out (pin_change),
      .fall_out   (pin_fall)
   );

   // ***************************************************
   // Source events
   // ***************************************************
   hwf_state_s        s;
   hwf_state_s        next_s;
   logic [NIB_W-1:0]  c_change;
   logic [NIB_W-1:0]  d_change;
   logic              c_masked;
   logic              d_masked;
   logic [FLAG_W-1:0] ev_set;
   logic [FLAG_W-1:0] hold_gate;
   logic [FLAG_W-1:0] cause_set;
   logic [FLAG_W-1:0] cause_clr;
   logic [FLAG_W-1:0] ev_clr;
   logic [FLAG_W-1:0] ev_load;
   logic [FLAG_W-1:0] ack_clr;
   logic [FLAG_W-1:0] hold_en_drop;
   logic              port_d_cause_clr;

   assign c_change = pin_change[PIN_C_LO +: NIB_W];
   assign d_change = pin_change[PIN_D_LO +: NIB_W];
   assign c_masked = |(c_change & s.port_change_mask[MASK_C_LO +: NIB_W]);
   assign d_masked = |(d_change & s.port_change_mask[MASK_D_LO +: NIB_W]);

   // Nine sources: eight in the shared order plus port D
   always_comb
   begin
      ev_set             = FLAGS_CLEAR;
      ev_set[SRC_DIV0]   = tick_in.div0_overflow;
      ev_set[SRC_TMR0]   = tick_in.tmr0_underflow;
      ev_set[SRC_PORT_C] = c_masked;
      ev_set[SRC_EXT0]   = pin_fall[PIN_EXT0];
      ev_set[SRC_DIV1]   = tick_in.div1_overflow;
      ev_set[SRC_SERIAL] = tick_in.serial_done;
      ev_set[SRC_EXT1]   = pin_fall[PIN_EXT1];
      ev_set[SRC_TMR1]   = tick_in.tmr1_underflow;
      hold_gate          = s.hold_release_enable;
      hold_gate[SRC_EXT0] = s.hold_release_enable[SRC_EXT0] & s.ext_edge_hold_mask[EXT0_MASK_BIT];
      hold_gate[SRC_EXT1] = s.hold_release_enable[SRC_EXT1] & s.ext_edge_hold_mask[EXT1_MASK_BIT];
      cause_set          = ev_set & hold_gate;
   end

   // ***************************************************
   // Software and accept clear terms
   // ***************************************************
   always_comb
   begin
      ev_clr       = FLAGS_CLEAR;
      ev_load      = FLAGS_CLEAR;
      hold_en_drop = FLAGS_CLEAR;
      case (cmd_in.op)
         OP_CLR_EVENT:
            ev_clr = cmd_in.data;
         OP_WR_EVENT:
         begin
            ev_clr  = ~cmd_in.data;
            ev_load = cmd_in.data;
         end
         OP_WR_HOLD_EN:
            hold_en_drop = ~cmd_in.data;
         default:
            ev_clr = FLAGS_CLEAR;
      endcase
      ack_clr = FLAGS_CLEAR;
      if (irq_ack_in && s.irq_req)
         ack_clr[s.irq_src] = 1'b1;
      // Only software clears reach the cause bits
      cause_clr = ev_clr | hold_en_drop;
      port_d_cause_clr = (cmd_in.op == OP_CLR_PORT_D_EVENT)
                      || (cmd_in.op == OP_WR_PORT_D_HOLD_EN && !cmd_in.data[0]);
   end

   logic [FLAG_W-1:0] next_cause;
   logic [FLAG_W-1:0] next_event;

   // Set wins over a clear in the same cycle
   for (genvar i = 0; i < FLAG_W; i++)
   begin : g_flag
      assign next_cause[i] = cause_set[i] | (s.hold_release_cause[i] & ~cause_clr[i]);
      assign next_event[i] = ev_set[i] | ev_load[i]
                           | (s.event_pending[i] & ~ev_clr[i] & ~ack_clr[i]);
   end

   // ***************************************************
   // Next state
   // ***************************************************
   logic [FLAG_W-1:0] irq_pend;

   always_comb
   begin
      next_s          = s;
      next_s.rd_valid = 1'b0;
      irq_pend        = FLAGS_CLEAR;
      case (cmd_in.op)
         OP_WR_HOLD_EN:        next_s.hold_release_enable = cmd_in.data;
         OP_WR_PORT_D_HOLD_EN: next_s.port_d_hold_enable  = cmd_in.data[0];
         OP_WR_IRQ_EN:         next_s.irq_enable          = cmd_in.data;
         OP_WR_PORT_MASK:      next_s.port_change_mask    = cmd_in.data;
         OP_WR_EXT_MASK:       next_s.ext_edge_hold_mask  = cmd_in.data[NIB_W-1:0];
         OP_WR_STOP_MASK:      next_s.stop_wake_mask      = cmd_in.data;
         OP_RD_EVENT:
         begin
            next_s.rd_data  = s.event_pending;
            next_s.rd_valid = 1'b1;
         end
         OP_RD_CAUSE_LOW:
         begin
            next_s.rd_data  = {NIB_CLEAR, s.hold_release_cause[NIB_W-1:0]};
            next_s.rd_valid = 1'b1;
         end
         OP_RD_CAUSE_HIGH:
         begin
            next_s.rd_data  = {NIB_CLEAR, s.hold_release_cause[FLAG_W-1:NIB_W]};
            next_s.rd_valid = 1'b1;
         end
         OP_RD_PORT_C_STATUS:
         begin
            next_s.rd_data  = {NIB_CLEAR, s.port_c_pin_change_status};
            next_s.rd_valid = 1'b1;
         end
         OP_RD_PORT_D_STATUS:
         begin
            next_s.rd_data  = {NIB_CLEAR, s.port_d_pin_change_status};
            next_s.rd_valid = 1'b1;
         end
         default:
            next_s.rd_valid = 1'b0;
      endcase

      next_s.hold_release_cause = next_cause;
      next_s.event_pending      = next_event;

      // Port D: hidden event and cause
      next_s.port_d_event = d_masked
                          | (s.port_d_event & (cmd_in.op != OP_CLR_PORT_D_EVENT));
      next_s.port_d_wake_cause = (d_masked & s.port_d_hold_enable)
                               | (s.port_d_wake_cause & ~port_d_cause_clr);

      // Per-pin change status, new change beats a clear
      next_s.port_c_pin_change_status = c_change
         | (s.port_c_pin_change_status & {NIB_W{cmd_in.op != OP_CLR_PORT_C_STATUS}});
      next_s.port_d_pin_change_status = d_change
         | (s.port_d_pin_change_status & {NIB_W{cmd_in.op != OP_CLR_PORT_D_STATUS}});

      // Global interrupt gate
      if (irq_ack_in && s.irq_req)
         next_s.global_irq_on = 1'b0;
      if (cmd_in.op == OP_WR_IRQ_EN || cmd_in.op == OP_GLOBAL_IRQ_ON)
         next_s.global_irq_on = 1'b1;
      if (cmd_in.op == OP_GLOBAL_IRQ_OFF)
         next_s.global_irq_on = 1'b0;

      // Port C events are already mask-gated at the source
      irq_pend       = next_s.event_pending & next_s.irq_enable;
      next_s.irq_req = next_s.global_irq_on & (|irq_pend);
      next_s.irq_src = s.irq_src;
      for (int k = FLAG_W - 1; k >= 0; k--)
      begin
         if (irq_pend[k])
            next_s.irq_src = k[SRC_IDX_W-1:0];
      end
      next_s.irq_vector = VEC_BASE + (VEC_W'(next_s.irq_src) << VEC_STEP_SHIFT);

      // Hold ends the moment any cause is present
      next_s.hold = (s.hold | (cmd_in.op == OP_ENTER_HOLD))
                  & ~((|next_s.hold_release_cause) | next_s.port_d_wake_cause);
      // Interrupt lifts the halt only; hold resumes after service
      next_s.core_halt = next_s.hold & ~next_s.irq_req;
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign hold_out           = s.hold;
   assign core_halt_out      = s.core_halt;
   assign irq_req_out        = s.irq_req;
   assign irq_vector_out     = s.irq_vector;
   assign rd_data_out        = s.rd_data;
   assign rd_valid_out       = s.rd_valid;
   assign stop_wake_mask_out = s.stop_wake_mask;

endmodule // hwf_hold_wake_flags
`default_nettype wire

// [verilog/hwf_pkg.sv]
// Shared types and constants for the hold / wake / interrupt flag block.
// Assumes one system clock; the core issues flag commands on that clock.
package hwf_pkg;

   // ***************************************************
   // Widths and source positions
   // ***************************************************
   localparam int FLAG_W     = 8;
   localparam int NIB_W      = 4;
   localparam int PIN_W      = 10;
   localparam int VEC_W      = 12;
   localparam int SRC_IDX_W  = 3;

   // Source order shared by enable, cause and event registers
   localparam int SRC_DIV0   = 0;
   localparam int SRC_TMR0   = 1;
   localparam int SRC_PORT_C = 2;
   localparam int SRC_EXT0   = 3;
   localparam int SRC_DIV1   = 4;
   localparam int SRC_SERIAL = 5;
   localparam int SRC_EXT1   = 6;
   localparam int SRC_TMR1   = 7;

   // Edge mask bits for the two external inputs
   localparam int EXT0_MASK_BIT = 2;
   localparam int EXT1_MASK_BIT = 3;

   // Synchronised pin vector layout
   localparam int PIN_C_LO   = 0;
   localparam int PIN_D_LO   = 4;
   localparam int PIN_EXT0   = 8;
   localparam int PIN_EXT1   = 9;

   // Port mask halves
   localparam int MASK_C_LO  = 0;
   localparam int MASK_D_LO  = 4;

   // Vector table placement, one slot per source
   localparam logic [VEC_W-1:0] VEC_BASE = 12'h004;
   localparam int               VEC_STEP_SHIFT = 2;

   localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 8'h00;
   localparam logic [NIB_W-1:0]  NIB_CLEAR   = 4'h0;

   // ***************************************************
   // Core command set
   // ***************************************************
   typedef enum logic [4:0] {
      OP_NONE,
      OP_WR_HOLD_EN,
      OP_WR_PORT_D_HOLD_EN,
      OP_WR_IRQ_EN,
      OP_WR_PORT_MASK,
      OP_WR_EXT_MASK,
      OP_WR_STOP_MASK,
      OP_CLR_EVENT,
      OP_CLR_PORT_D_EVENT,
      OP_WR_EVENT,
      OP_RD_EVENT,
      OP_RD_CAUSE_LOW,
      OP_RD_CAUSE_HIGH,
      OP_RD_PORT_C_STATUS,
      OP_RD_PORT_D_STATUS,
      OP_CLR_PORT_C_STATUS,
      OP_CLR_PORT_D_STATUS,
      OP_GLOBAL_IRQ_ON,
      OP_GLOBAL_IRQ_OFF,
      OP_ENTER_HOLD
   } hwf_op_e;

   typedef struct packed {
      hwf_op_e             op;
      logic [FLAG_W-1:0]   data;
   } hwf_cmd_s;

   // Internal single-cycle events from timers, dividers and serial unit
   typedef struct packed {
      logic tmr1_underflow;
      logic serial_done;
      logic div1_overflow;
      logic tmr0_underflow;
      logic div0_overflow;
   } hwf_tick_s;

   typedef struct packed {
      logic [FLAG_W-1:0] hold_release_enable;
      logic              port_d_hold_enable;
      logic [FLAG_W-1:0] irq_enable;
      logic [FLAG_W-1:0] port_change_mask;
      logic [NIB_W-1:0]  ext_edge_hold_mask;
      logic [FLAG_W-1:0] stop_wake_mask;
      logic [FLAG_W-1:0] hold_release_cause;
      logic              port_d_wake_cause;
      logic [FLAG_W-1:0] event_pending;
      logic              port_d_event;
      logic [NIB_W-1:0]  port_c_pin_change_status;
      logic [NIB_W-1:0]  port_d_pin_change_status;
      logic              global_irq_on;
      logic              hold;
      logic              core_halt;
      logic              irq_req;
      logic [SRC_IDX_W-1:0] irq_src;
      logic [VEC_W-1:0]  irq_vector;
      logic [FLAG_W-1:0] rd_data;
      logic              rd_valid;
   } hwf_state_s;

endpackage : hwf_pkg

// [verilog/hwf_sync2.sv]
// Two-stage synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to clk_in; reset is already synchronous-released.
`timescale 1ns/1ps
`default_nettype none
module hwf_sync2
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage is read only by the second stage
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
         begin
            stage1[i]   <= 1'b0;
            sync_out[i] <= 1'b0;
         end
         else
         begin
            stage1[i]   <= async_in[i];
            sync_out[i] <= stage1[i];
         end
      end
   end

endmodule // hwf_sync2
`default_nettype wire

// [verilog/hwf_pin_watch.sv]
// Change and falling-edge detector on already synchronised pins.
// Assumes inputs are on clk_in; first three samples after reset only prime history.
`timescale 1ns/1ps
`default_nettype none
module hwf_pin_watch
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] change_out,
   output var  logic [WIDTH-1:0] fall_out
);

   // Two sync stages plus one history stage
   localparam int PRIME_STAGES = 3;

   logic [WIDTH-1:0]        prev;
   logic [PRIME_STAGES-1:0] prime_pipe;
   logic                    primed;

   // Priming waits for a real pin sample in history, so reset levels are no change
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prev       <= '0;
         prime_pipe <= '0;
      end
      else
      begin
         prev       <= pin_in;
         prime_pipe <= {prime_pipe[PRIME_STAGES-2:0], 1'b1};
      end
   end

   assign primed = prime_pipe[PRIME_STAGES-1];

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      assign change_out[i] = primed & (prev[i] ^ pin_in[i]);
      assign fall_out[i]   = primed & prev[i] & ~pin_in[i];
   end

endmodule // hwf_pin_watch
`default_nettype wire

// [testbench/hwf_flags_properties.sv]
// Port checker for the hold / wake / interrupt flag block.
// Assumes it is bound to hwf_hold_wake_flags on its single clock.
`timescale 1ns/1ps
`default_nettype none
module hwf_flags_properties
   import hwf_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire hwf_cmd_s          cmd_in,
   input  wire logic              irq_ack_in,
   input  wire logic              hold_out,
   input  wire logic              core_halt_out,
   input  wire logic              irq_req_out,
   input  wire logic [VEC_W-1:0]  irq_vector_out,
   input  wire logic [FLAG_W-1:0] rd_data_out,
   input  wire logic              rd_valid_out
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic rd_op;
   logic keep_op;
   assign rd_op = cmd_in.op inside {OP_RD_EVENT, OP_RD_CAUSE_LOW, OP_RD_CAUSE_HIGH,
                                    OP_RD_PORT_C_STATUS, OP_RD_PORT_D_STATUS};
   // Only these ops may drop a standing request
   assign keep_op = !(cmd_in.op inside {OP_GLOBAL_IRQ_OFF, OP_WR_IRQ_EN, OP_CLR_EVENT, OP_WR_EVENT});

   chk_halt_def: assert property (core_halt_out == (hold_out && !irq_req_out))
      else $error("halt differs from hold and request");
   chk_hold_entry: assert property ($rose(hold_out) |-> $past(cmd_in.op) == OP_ENTER_HOLD)
      else $error("hold entered without command");
   chk_hold_stays: assert property (!hold_out && cmd_in.op != OP_ENTER_HOLD |=> !hold_out)
      else $error("hold rose by itself");
   chk_rd_pulse: assert property (rd_op |=> rd_valid_out)
      else $error("read gave no valid");
   chk_rd_quiet: assert property (!rd_op |=> !rd_valid_out)
      else $error("valid without read");
   chk_cause_nibble: assert property (rd_valid_out && $past(cmd_in.op) inside {OP_RD_CAUSE_LOW, OP_RD_CAUSE_HIGH}
      |-> rd_data_out[7:4] == 4'h0)
      else $error("cause nibble upper bits set");
   chk_vec_slot: assert property (irq_req_out |-> irq_vector_out inside {[12'h004:12'h020]}
      && irq_vector_out[1:0] == 2'h0)
      else $error("vector outside table");
   chk_ack_masks: assert property (irq_req_out && irq_ack_in && !(cmd_in.op inside {OP_WR_IRQ_EN, OP_GLOBAL_IRQ_ON})
      |=> !irq_req_out)
      else $error("request stood after ack");
   chk_off_masks: assert property (cmd_in.op == OP_GLOBAL_IRQ_OFF |=> !irq_req_out)
      else $error("request after global off");
   chk_req_stands: assert property (irq_req_out && !irq_ack_in && keep_op |=> irq_req_out)
      else $error("request dropped by itself");
   chk_reset_quiet: assert property ($rose(reset_n_in) |-> (!hold_out && !irq_req_out && !rd_valid_out) [*3])
      else $error("outputs active after reset");

   cov_wake: cover property ($fell(hold_out));
   cov_ack: cover property (irq_req_out && irq_ack_in);
   cov_irq_hold: cover property (hold_out && irq_req_out);
endmodule // hwf_flags_properties

bind hwf_hold_wake_flags hwf_flags_properties i_hwf_flags_properties (.clk_in, .reset_n_in, .cmd_in,
   .irq_ack_in, .hold_out, .core_halt_out, .irq_req_out, .irq_vector_out, .rd_data_out, .rd_valid_out);
`default_nettype wire

// [testbench/hwf_core_model.sv]
// Core model: takes the interrupt after a chosen delay.
// Assumes the same clock as the flag block.
`timescale 1ns/1ps
`default_nettype none
module hwf_core_model
(
   input  wire logic       clk_in,
   input  wire logic       ack_en_in,
   input  wire logic [3:0] delay_in,
   input  wire logic       irq_req_in,
   output var  logic       irq_ack_out
);
   // ****************************************
   // Acknowledge
   // ****************************************
   logic [3:0] wait_cnt;
   initial
   begin
      irq_ack_out = 1'b0;
      wait_cnt = 4'h0;
   end
   // One pulse per request, slow or prompt
   always @(posedge clk_in)
   begin
      if (irq_ack_out || !irq_req_in || !ack_en_in)
      begin
         irq_ack_out <= 1'b0;
         wait_cnt <= 4'h0;
      end
      else if (wait_cnt >= delay_in)
         irq_ack_out <= 1'b1;
      else
         wait_cnt <= wait_cnt + 4'h1;
   end
endmodule // hwf_core_model
`default_nettype wire

// [testbench/tb_hwf_hold_wake_flags.sv]
// Self-checking bench for the flag block with core model.
// Assumes the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module tb_hwf_hold_wake_flags
   import hwf_pkg::*;
   ;
   // ****************************************
   // Signals and helpers
   // ****************************************
   logic              clk_in, reset_n_in, irq_ack_in, ack_en;
   hwf_cmd_s          cmd_in;
   hwf_tick_s         tick_in;
   logic [NIB_W-1:0]  port_c_pin_in, port_d_pin_in;
   logic              first_ext_edge_input_in, second_ext_edge_input_in;
   logic              hold_out, core_halt_out, irq_req_out, rd_valid_out;
   logic [VEC_W-1:0]  irq_vector_out;
   logic [FLAG_W-1:0] rd_data_out, stop_wake_mask_out, rd, cz, hen;
   logic [3:0]        delay;
   int                n_mismatch, checked, seed, cycles;

   hwf_hold_wake_flags i_hwf_hold_wake_flags (.clk_in, .reset_n_in, .cmd_in, .tick_in, .irq_ack_in,
      .port_c_pin_in, .port_d_pin_in, .first_ext_edge_input_in, .second_ext_edge_input_in, .hold_out,
      .core_halt_out, .irq_req_out, .irq_vector_out, .rd_data_out, .rd_valid_out, .stop_wake_mask_out);
   hwf_core_model i_hwf_core_model (.clk_in, .ack_en_in(ack_en), .delay_in(delay),
      .irq_req_in(irq_req_out), .irq_ack_out(irq_ack_in));

   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function automatic int src_bit(int k);
      return (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 4 : (k == 3) ? 5 : 7;
   endfunction
   function automatic logic [11:0] vec(int s);
      return VEC_BASE + (12'(s) << VEC_STEP_SHIFT);
   endfunction

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic op(input hwf_op_e o, input logic [7:0] d);
      @(posedge clk_in);
      cmd_in <= '{o, d};
      @(posedge clk_in);
      cmd_in <= '{OP_NONE, 8'h00};
      #1;
      rd = rd_data_out;
   endtask
   task automatic rd_cause(output logic [7:0] c);
      op(OP_RD_CAUSE_LOW, 8'h00);
      c[3:0] = rd[3:0];
      op(OP_RD_CAUSE_HIGH, 8'h00);
      c[7:4] = rd[3:0];
   endtask
   task automatic tick(input logic [4:0] t);
      @(posedge clk_in);
      tick_in <= hwf_tick_s'(t);
      @(posedge clk_in);
      tick_in <= '0;
      #1;
   endtask
   // Fixed wait covers two sync stages and the detect stage
   task automatic pins(input logic [3:0] c, input logic [3:0] d, input logic e0, input logic e1);
      @(posedge clk_in);
      port_c_pin_in <= c;
      port_d_pin_in <= d;
      first_ext_edge_input_in <= e0;
      second_ext_edge_input_in <= e1;
      repeat (6) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_low();
      for (int i = 0; i < 30 && irq_req_out !== 1'b0; i++)
      begin
         @(posedge clk_in);
         #1;
      end
   endtask
   task automatic rst_chk();
      op(OP_RD_EVENT, 8'h00);
      check("event", rd, 0);
      rd_cause(cz);
      check("cause", cz, 0);
      op(OP_RD_PORT_C_STATUS, 8'h00);
      check("c status", rd, 0);
      op(OP_RD_PORT_D_STATUS, 8'h00);
      check("d status", rd, 0);
      check("stop mask", stop_wake_mask_out, 0);
      check("irq", irq_req_out, 0);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      seed = 71264;
      n_mismatch = 0;
      checked = 0;
      cycles = 0;
      reset_n_in = 1'b0;
      cmd_in = '{OP_NONE, 8'h00};
      tick_in = '0;
      port_c_pin_in = 4'h0;
      port_d_pin_in = 4'h0;
      first_ext_edge_input_in = 1'b1;
      second_ext_edge_input_in = 1'b1;
      ack_en = 1'b1;
      delay = 4'h0;
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rst_chk();
      $display("test reset done");
      for (int k = 0; k < 5; k++)
      begin
         int s;
         int o;
         s = src_bit(k);
         o = src_bit((k + 1) % 5);
         hen = ((8'($random(seed)) | (8'h01 << s)) & ~(8'h01 << o)) & 8'hB3;
         op(OP_WR_HOLD_EN, hen);
         op(OP_ENTER_HOLD, 8'h00);
         check("hold in", hold_out, 1);
         check("halt in", core_halt_out, 1);
         tick(5'h01 << ((k + 1) % 5));
         check("hold other", hold_out, 1);
         tick(5'h01 << k);
         check("hold woke", hold_out, 0);
         op(OP_RD_EVENT, 8'h00);
         check("event", rd, (12'h1 << s) | (12'h1 << o));
         rd_cause(cz);
         check("cause", cz, 12'h1 << s);
         op(OP_WR_HOLD_EN, 8'h00);
         rd_cause(cz);
         check("cause clr", cz, 0);
         op(OP_CLR_EVENT, 8'hFF);
         op(OP_RD_EVENT, 8'h00);
         check("event clr", rd, 0);
      end
      $display("test tick wake done");
      op(OP_WR_EXT_MASK, 8'h04);
      op(OP_WR_HOLD_EN, 8'h48);
      op(OP_ENTER_HOLD, 8'h00);
      pins(4'h0, 4'h0, 1'b1, 1'b0);
      check("ext1 masked", hold_out, 1);
      pins(4'h0, 4'h0, 1'b0, 1'b0);
      check("ext0 wake", hold_out, 0);
      op(OP_RD_EVENT, 8'h00);
      check("ext event", rd, 8'h48);
      rd_cause(cz);
      check("ext cause", cz, 8'h08);
      op(OP_CLR_EVENT, 8'hFF);
      pins(4'h0, 4'h0, 1'b1, 1'b1);
      op(OP_RD_EVENT, 8'h00);
      check("rise quiet", rd, 0);
      $display("test ext done");
      op(OP_WR_PORT_MASK, 8'h11);
      op(OP_WR_PORT_D_HOLD_EN, 8'h01);
      op(OP_WR_HOLD_EN, 8'h00);
      op(OP_ENTER_HOLD, 8'h00);
      pins(4'h2, 4'h0, 1'b1, 1'b1);
      op(OP_RD_EVENT, 8'h00);
      check("c masked", rd, 0);
      pins(4'h3, 4'h0, 1'b1, 1'b1);
      op(OP_RD_EVENT, 8'h00);
      check("c event", rd, 8'h04);
      op(OP_RD_PORT_C_STATUS, 8'h00);
      check("c status", rd, 8'h03);
      pins(4'h3, 4'h1, 1'b1, 1'b1);
      check("d wake", hold_out, 0);
      rd_cause(cz);
      check("d hidden", cz, 0);
      op(OP_RD_PORT_D_STATUS, 8'h00);
      check("d status", rd, 8'h01);
      op(OP_CLR_PORT_D_EVENT, 8'h00);
      op(OP_ENTER_HOLD, 8'h00);
      check("d cause clr", hold_out, 1);
      op(OP_WR_HOLD_EN, 8'h01);
      tick(5'h01);
      check("div0 wake", hold_out, 0);
      op(OP_CLR_EVENT, 8'hFF);
      op(OP_CLR_PORT_C_STATUS, 8'h00);
      op(OP_CLR_PORT_D_STATUS, 8'h00);
      op(OP_RD_PORT_C_STATUS, 8'h00);
      check("c status clr", rd, 0);
      $display("test ports done");
      delay <= 4'($random(seed)) & 4'h7;
      op(OP_WR_IRQ_EN, 8'h82);
      tick(5'h12);
      check("irq", irq_req_out, 1);
      check("vector", irq_vector_out, vec(1));
      wait_low();
      check("irq taken", irq_req_out, 0);
      op(OP_RD_EVENT, 8'h00);
      check("event kept", rd, 8'h80);
      ack_en <= 1'b0;
      op(OP_GLOBAL_IRQ_ON, 8'h00);
      @(posedge clk_in);
      #1;
      check("irq on", irq_req_out, 1);
      check("vector", irq_vector_out, vec(7));
      op(OP_GLOBAL_IRQ_OFF, 8'h00);
      @(posedge clk_in);
      #1;
      check("irq off", irq_req_out, 0);
      ack_en <= 1'b1;
      op(OP_WR_IRQ_EN, 8'h80);
      repeat (2) @(posedge clk_in);
      wait_low();
      op(OP_RD_EVENT, 8'h00);
      check("event taken", rd, 0);
      $display("test irq done");
      ack_en <= 1'b0;
      op(OP_WR_HOLD_EN, 8'h00);
      op(OP_WR_IRQ_EN, 8'h01);
      op(OP_ENTER_HOLD, 8'h00);
      tick(5'h01);
      check("irq hold", hold_out, 1);
      check("halt off", core_halt_out, 0);
      ack_en <= 1'b1;
      wait_low();
      check("halt back", core_halt_out, 1);
      op(OP_WR_HOLD_EN, 8'h01);
      tick(5'h01);
      check("hold exit", hold_out, 0);
      $display("test irq hold done");
      hen = 8'($random(seed)) | 8'h01;
      op(OP_WR_STOP_MASK, hen);
      check("stop mask wr", stop_wake_mask_out, hen);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rst_chk();
      $display("test mid reset done");
      complete_run();
   end
endmodule // tb_hwf_hold_wake_flags
`default_nettype wire
